//--- design/tpwm_pkg.sv
// Package of register map, field layout and encodings for the timer PWM block
`default_nettype none
package tpwm_pkg;
	// ----------------------------------------------------------------
	// Register map, channel n at n*CH_STRIDE + field offset
	// ----------------------------------------------------------------
	localparam logic [11:0] CH_STRIDE    = 12'h020;
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_IOCTL    = 12'h004;
	localparam logic [11:0] OFF_COUNT    = 12'h008;
	localparam logic [11:0] OFF_RISE     = 12'h00c;
	localparam logic [11:0] OFF_FALL     = 12'h010;
	localparam logic [11:0] OFF_MODE     = 12'h014;
	localparam logic [11:0] ADDR_START   = 12'h100;
	localparam logic [11:0] ADDR_COMB    = 12'h104;
	localparam logic [11:0] ADDR_STATUS  = 12'h108;
	localparam int          NUM_CH       = 5;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PSC_LSB   = 0;
	localparam int CTRL_EDGE_LSB  = 3;
	localparam int CTRL_CLR_LSB   = 5;
	localparam int IO_SEC_LSB     = 4;
	localparam int COMB_LSB       = 0;
	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] CLR_NONE   = 2'h0;
	localparam logic [1:0] CLR_RISE   = 2'h1;
	localparam logic [1:0] CLR_FALL   = 2'h2;
	localparam logic [1:0] CLR_SYNC   = 2'h3;
	localparam logic [1:0] COMB_RSYNC = 2'h2;
	localparam logic [2:0] PSC_DIV1   = 3'h0;
	localparam logic [2:0] PSC_DIV2   = 3'h1;
	localparam logic [2:0] PSC_DIV4   = 3'h2;
	localparam logic [2:0] PSC_DIV8   = 3'h3;
	localparam logic [1:0] IO_ZERO    = 2'h1;
	localparam logic [1:0] IO_ONE     = 2'h2;
	localparam logic [1:0] IO_TOGGLE  = 2'h3;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] GR_RESET  = 16'hffff;
endpackage : tpwm_pkg
`default_nettype wire

//--- design/tpwm_clk_sel.sv
// Count-clock selector: prescaler and synchronised external edge detection
`default_nettype none
module tpwm_clk_sel (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Configuration
	input  wire logic [2:0] prescale_select,
	input  wire logic       edge_select_hi,
	input  wire logic       edge_select_lo,
	// External count clocks, asynchronous
	input  wire logic [3:0] ext_clk,
	// Count pulse
	output logic            count_tick
);
	logic [2:0] div_reg, div_next;
	logic [3:0] s1_reg, s2_reg, s3_reg;
	logic [3:0] lvl_reg, lvl_next;
	logic       tick_reg, tick_next;

	// Prescaler and three-stage synchroniser
	always_comb begin
		logic rise;
		logic fall;
		logic [1:0] k;
		rise = 1'b0;
		fall = 1'b0;
		k = 2'h0;
		div_next = div_reg + 3'h1;
		tick_next = 1'b0;
		// Accepted level moves only once the second and third stages agree
		lvl_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
		case (prescale_select)
			tpwm_pkg::PSC_DIV1: tick_next = 1'b1;
			tpwm_pkg::PSC_DIV2: tick_next = (div_reg[0] == 1'b1);
			tpwm_pkg::PSC_DIV4: tick_next = (div_reg[1:0] == 2'h3);
			tpwm_pkg::PSC_DIV8: tick_next = (div_reg == 3'h7);
			default: begin
				k = prescale_select[1:0];
				rise = (s2_reg[k] == s3_reg[k]) & s3_reg[k] & ~lvl_reg[k];
				fall = (s2_reg[k] == s3_reg[k]) & ~s3_reg[k] & lvl_reg[k];
				// Edge choice: 00 rising, 01 falling, 1x both
				if (edge_select_hi) begin
					tick_next = rise | fall;
				end else if (edge_select_lo) begin
					tick_next = fall;
				end else begin
					tick_next = rise;
				end
			end
		endcase
	end

	// Registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_reg  <= 3'h0;
			s1_reg   <= 4'h0;
			s2_reg   <= 4'h0;
			s3_reg   <= 4'h0;
			lvl_reg  <= 4'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			s1_reg   <= ext_clk;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			lvl_reg  <= lvl_next;
			tick_reg <= tick_next;
		end
	end

	assign count_tick = tick_reg;
endmodule : tpwm_clk_sel
`default_nettype wire

//--- design/tpwm_top.sv
// Five-channel 16-bit timer with PWM and reset-synchronised PWM outputs
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module tpwm_top (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// External count clocks
	input  wire logic [3:0]  ext_clk,
	// Pins
	output logic [4:0]       primary_match_pin,
	output logic [4:0]       secondary_match_pin,
	output logic             pair2_neg_pin,
	output logic             pair3_neg_pin
);
	typedef enum logic [1:0] {
		TPWM_IDLE   = 2'b00,
		TPWM_ACCESS = 2'b01
	} tpwm_apb_e;

	localparam int N = tpwm_pkg::NUM_CH;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_reg [N], ctrl_next [N];
	logic [5:0]  ioctl_reg [N], ioctl_next [N];
	logic [15:0] cnt_reg [N], cnt_next [N];
	logic [15:0] rise_reg [N], rise_next [N];
	logic [15:0] fall_reg [N], fall_next [N];
	logic [N-1:0] mode_reg, mode_next;
	logic [N-1:0] start_reg, start_next;
	logic [N-1:0] sync_reg, sync_next;
	logic [1:0]  comb_reg, comb_next;
	logic [N-1:0] pa_reg, pa_next, pb_reg, pb_next;
	logic        n2_reg, n2_next, n3_reg, n3_next;
	logic [31:0] rdata_reg, rdata_next;
	tpwm_apb_e   apb_reg, apb_next;
	logic [N-1:0] tick;
	logic [N-1:0] match_a, match_b;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] clr_sel(input logic [7:0] c);
		clr_sel = c[tpwm_pkg::CTRL_CLR_LSB +: 2];
	endfunction : clr_sel

	// Apply io control action: 1 zero, 2 one, 3 toggle
	function automatic logic io_apply(input logic [1:0] io, input logic cur);
		case (io)
			tpwm_pkg::IO_ZERO:   io_apply = 1'b0;
			tpwm_pkg::IO_ONE:    io_apply = 1'b1;
			tpwm_pkg::IO_TOGGLE: io_apply = ~cur;
			default:             io_apply = cur;
		endcase
	endfunction : io_apply

	function automatic logic [11:0] reg_addr(input int ch, input logic [11:0] off);
		reg_addr = 12'(ch) * tpwm_pkg::CH_STRIDE + off;
	endfunction : reg_addr

	logic rsync;
	assign rsync = (comb_reg == tpwm_pkg::COMB_RSYNC);

	// ----------------------------------------------------------------
	// Count clocks
	// ----------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_clk
		tpwm_clk_sel u_clk (
			.sys_clk         (sys_clk),
			.rst             (rst),
			.prescale_select (ctrl_reg[g][tpwm_pkg::CTRL_PSC_LSB +: 3]),
			.edge_select_hi  (ctrl_reg[g][tpwm_pkg::CTRL_EDGE_LSB + 1]),
			.edge_select_lo  (ctrl_reg[g][tpwm_pkg::CTRL_EDGE_LSB]),
			.ext_clk         (ext_clk),
			.count_tick      (tick[g])
		);
	end

	// Match fires when counter leaves the matching value
	always_comb begin
		for (int i = 0; i < N; i++) begin
			match_a[i] = start_reg[i] & tick[i] & (cnt_reg[i] == rise_reg[i]);
			match_b[i] = start_reg[i] & tick[i] & (cnt_reg[i] == fall_reg[i]);
		end
	end

	// ----------------------------------------------------------------
	// Counters, pins and APB
	// ----------------------------------------------------------------
	always_comb begin
		logic [N-1:0] clr;
		logic         sync_clr;
		logic         wr;
		logic [11:0]  a;
		clr = '0;
		sync_clr = 1'b0;
		wr = (apb_reg == TPWM_ACCESS) & pwrite;
		a = paddr;
		apb_next = TPWM_IDLE;
		rdata_next = rdata_reg;
		mode_next = mode_reg;
		start_next = start_reg;
		sync_next = sync_reg;
		comb_next = comb_reg;
		pa_next = pa_reg;
		pb_next = pb_reg;
		n2_next = n2_reg;
		n3_next = n3_reg;
		// Own compare-match clears, for channel 3 in reset-sync too; a clear on a synced channel sets sync_clr
		for (int i = 0; i < N; i++) begin
			case (clr_sel(ctrl_reg[i]))
				tpwm_pkg::CLR_RISE: clr[i] = match_a[i];
				tpwm_pkg::CLR_FALL: clr[i] = match_b[i];
				default:            clr[i] = 1'b0;
			endcase
			if (sync_reg[i] && clr[i]) begin
				sync_clr = 1'b1;
			end
		end
		for (int i = 0; i < N; i++) begin
			ctrl_next[i] = ctrl_reg[i];
			ioctl_next[i] = ioctl_reg[i];
			rise_next[i] = rise_reg[i];
			fall_next[i] = fall_reg[i];
			cnt_next[i] = cnt_reg[i];
			if (start_reg[i] && tick[i]) begin
				cnt_next[i] = cnt_reg[i] + 16'h0001;
			end
			// Synchronised clear across channels
			if (clr[i] || (sync_reg[i] && sync_clr &&
				clr_sel(ctrl_reg[i]) == tpwm_pkg::CLR_SYNC)) begin
				cnt_next[i] = tpwm_pkg::CNT_RESET;
			end
			// Pin behaviour per mode
			if (rsync && (i == 3 || i == 4)) begin
				// Driven below from channel 3 counter
			end else if (mode_reg[i]) begin
				// Equal values: neither edge applies
				if (match_a[i] && !(rise_reg[i] == fall_reg[i])) begin
					pa_next[i] = 1'b1;
				end
				if (match_b[i] && !(rise_reg[i] == fall_reg[i])) begin
					pa_next[i] = 1'b0;
				end
				if (match_b[i]) begin
					pb_next[i] = io_apply(ioctl_reg[i][tpwm_pkg::IO_SEC_LSB +: 2],
						pb_reg[i]);
				end
			end else begin
				if (match_a[i]) begin
					pa_next[i] = io_apply(ioctl_reg[i][1:0], pa_reg[i]);
				end
				if (match_b[i]) begin
					pb_next[i] = io_apply(ioctl_reg[i][tpwm_pkg::IO_SEC_LSB +: 2],
						pb_reg[i]);
				end
			end
		end
		// Reset-sync: all three phases toggle on own turn match and period clear
		if (rsync) begin
			if (match_b[3] != clr[3]) begin
				pa_next[3] = ~pa_reg[3];
			end
			if ((start_reg[3] && tick[3] && cnt_reg[3] == rise_reg[4]) != clr[3]) begin
				pa_next[4] = ~pa_reg[4];
			end
			if ((start_reg[3] && tick[3] && cnt_reg[3] == fall_reg[4]) != clr[3]) begin
				pb_next[4] = ~pb_reg[4];
			end
			if (match_a[3] && cnt_reg[3] == fall_reg[3] && clr[3]) begin
				pa_next[3] = pa_reg[3];
			end
		end
		// APB access
		case (apb_reg)
			TPWM_IDLE: begin
				if (psel && !penable) begin
					apb_next = TPWM_ACCESS;
				end
			end
			default: apb_next = TPWM_IDLE;
		endcase
		// Decode from the setup cycle on, so read data stands in the access cycle
		case (apb_next == TPWM_ACCESS || apb_reg == TPWM_ACCESS)
			1'b1: begin
				rdata_next = 32'h0000_0000;
				for (int i = 0; i < N; i++) begin
					if (a == reg_addr(i, tpwm_pkg::OFF_CTRL)) begin
						rdata_next = {24'h0, ctrl_reg[i]};
						if (wr) ctrl_next[i] = pwdata[7:0];
					end
					if (a == reg_addr(i, tpwm_pkg::OFF_IOCTL)) begin
						rdata_next = {26'h0, ioctl_reg[i]};
						if (wr) ioctl_next[i] = pwdata[5:0];
					end
					if (a == reg_addr(i, tpwm_pkg::OFF_COUNT)) begin
						rdata_next = {16'h0, cnt_reg[i]};
						// Synchronised preset writes all synced counters
						if (wr) begin
							for (int j = 0; j < N; j++) begin
								if (j == i || (sync_reg[i] && sync_reg[j])) begin
									cnt_next[j] = pwdata[15:0];
								end
							end
						end
					end
					if (a == reg_addr(i, tpwm_pkg::OFF_RISE)) begin
						rdata_next = {16'h0, rise_reg[i]};
						if (wr) rise_next[i] = pwdata[15:0];
					end
					if (a == reg_addr(i, tpwm_pkg::OFF_FALL)) begin
						rdata_next = {16'h0, fall_reg[i]};
						if (wr) fall_next[i] = pwdata[15:0];
					end
				end
				if (a == tpwm_pkg::ADDR_START) begin
					rdata_next = {22'h0, sync_reg, start_reg};
					if (wr) begin
						start_next = pwdata[4:0];
						sync_next = pwdata[9:5];
					end
				end
				if (a == tpwm_pkg::ADDR_COMB) begin
					rdata_next = {25'h0, comb_reg, mode_reg};
					if (wr) begin
						mode_next = pwdata[4:0];
						comb_next = pwdata[6:5];
						// Newly selected outputs start at 0
						pa_next = pa_reg & ~(pwdata[4:0] & ~mode_reg);
						if (pwdata[6:5] == tpwm_pkg::COMB_RSYNC) begin
							pa_next[3] = 1'b0;
							pa_next[4] = 1'b0;
							pb_next[4] = 1'b0;
						end
					end
				end
				if (a == tpwm_pkg::ADDR_STATUS) begin
					rdata_next = {22'h0, pb_reg, pa_reg};
				end
			end
			default: rdata_next = rdata_reg;
		endcase
		// Negative phases from the same next values: change together
		n2_next = ~pa_next[4];
		n3_next = ~pb_next[4];
	end

	// Registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				ctrl_reg[i]  <= 8'h00;
				ioctl_reg[i] <= 6'h00;
				cnt_reg[i]   <= tpwm_pkg::CNT_RESET;
				rise_reg[i]  <= tpwm_pkg::GR_RESET;
				fall_reg[i]  <= tpwm_pkg::GR_RESET;
			end
			mode_reg  <= 5'h00;
			start_reg <= 5'h00;
			sync_reg  <= 5'h00;
			comb_reg  <= 2'h0;
			pa_reg    <= 5'h00;
			pb_reg    <= 5'h00;
			n2_reg    <= 1'b1;
			n3_reg    <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			apb_reg   <= TPWM_IDLE;
		end else begin
			ctrl_reg  <= ctrl_next;
			ioctl_reg <= ioctl_next;
			cnt_reg   <= cnt_next;
			rise_reg  <= rise_next;
			fall_reg  <= fall_next;
			mode_reg  <= mode_next;
			start_reg <= start_next;
			sync_reg  <= sync_next;
			comb_reg  <= comb_next;
			pa_reg    <= pa_next;
			pb_reg    <= pb_next;
			n2_reg    <= n2_next;
			n3_reg    <= n3_next;
			rdata_reg <= rdata_next;
			apb_reg   <= apb_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata  = rdata_reg;
	assign pready  = (apb_reg == TPWM_ACCESS);
	assign pslverr = 1'b0;
	assign primary_match_pin = pa_reg;
	// Pair 1 negative on channel 3 secondary pin
	always_comb begin
		secondary_match_pin = pb_reg;
		if (rsync) begin
			secondary_match_pin[3] = ~pa_reg[3];
		end
	end
	assign pair2_neg_pin = rsync ? n2_reg : 1'b0;
	assign pair3_neg_pin = rsync ? n3_reg : 1'b0;
endmodule : tpwm_top
`default_nettype wire

//--- bench/tpwm_load.sv
// Pin load model: counts high cycles per pin and equal pair levels
`default_nettype none
module tpwm_load (
	// Clock
	input  wire logic        sys_clk,
	// Measurement window
	input  wire logic        cnt_en,
	// Pins: primary [4:0], secondary [9:5], pair2 neg [10], pair3 neg [11]
	input  wire logic [11:0] pins,
	// Results
	output logic      [15:0] hi_cnt [12],
	output logic      [15:0] eq_cnt
);
	timeunit 1ns;
	timeprecision 1ns;

	// Count while the window is open, restart when it closes
	always @(posedge sys_clk) begin
		for (int i = 0; i < 12; i++) begin
			hi_cnt[i] <= !cnt_en ? 16'h0000 : hi_cnt[i] + {15'h0000, pins[i] === 1'b1};
		end
		if (!cnt_en) begin
			eq_cnt <= 16'h0000;
		end else if (pins[3] === pins[8] || pins[4] === pins[10] || pins[9] === pins[11]) begin
			eq_cnt <= eq_cnt + 16'h0001; // Pair levels alike: a glitch on the load
		end
	end
endmodule : tpwm_load
`default_nettype wire

//--- bench/tpwm_top_chk.sv
// Checker of bus handshake and pin pairing at the timer ports
`default_nettype none
module tpwm_top_chk (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Bus handshake
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// Pins
	input wire logic [4:0] primary_match_pin,
	input wire logic [4:0] secondary_match_pin,
	input wire logic       pair2_neg_pin,
	input wire logic       pair3_neg_pin
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	no_error_resp_a: assert property (!pslverr)
		else $error("slave error response raised");
	setup_answered_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	reset_pins_a: assert property ($fell(rst) |-> primary_match_pin == 5'h00 &&
		secondary_match_pin == 5'h00 && !pair2_neg_pin && !pair3_neg_pin)
		else $error("pins not low after reset");
	pair2_inverse_a: assert property (pair2_neg_pin |-> !primary_match_pin[4])
		else $error("pair two outputs both high");
	pair3_inverse_a: assert property (pair3_neg_pin |-> !secondary_match_pin[4])
		else $error("pair three outputs both high");
	pair2_together_a: assert property ($rose(primary_match_pin[4]) && $past(pair2_neg_pin)
		|-> $fell(pair2_neg_pin))
		else $error("pair two edges split");
	pair3_together_a: assert property ($rose(secondary_match_pin[4]) && $past(pair3_neg_pin)
		|-> $fell(pair3_neg_pin))
		else $error("pair three edges split");

	// Main scenarios reached
	cover property ($rose(primary_match_pin[0]));
	cover property ($fell(pair2_neg_pin));
	cover property ($rose(pair3_neg_pin));
	cover property (pready);
endmodule : tpwm_top_chk

bind tpwm_top tpwm_top_chk u_tpwm_top_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr),
	.primary_match_pin(primary_match_pin), .secondary_match_pin(secondary_match_pin),
	.pair2_neg_pin(pair2_neg_pin), .pair3_neg_pin(pair3_neg_pin));
`default_nettype wire

//--- bench/tpwm_top_test.sv
// Self-checking bench of the timer PWM and reset-synchronised outputs
`default_nettype none
module tpwm_top_test;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [3:0]  ext_clk = 4'h0;
	logic        cnt_en  = 1'b0;
	logic [31:0] seed    = 32'd70;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, pair2_neg_pin, pair3_neg_pin;
	logic [4:0]  primary_match_pin, secondary_match_pin;
	logic [15:0] hi_cnt [12];
	logic [15:0] eq_cnt;
	int          fail_count = 0;
	int          n_checks   = 0;

	tpwm_top u_tpwm_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk(ext_clk), .primary_match_pin(primary_match_pin),
		.secondary_match_pin(secondary_match_pin), .pair2_neg_pin(pair2_neg_pin),
		.pair3_neg_pin(pair3_neg_pin));
	tpwm_load u_tpwm_load (.sys_clk(sys_clk), .cnt_en(cnt_en), .hi_cnt(hi_cnt),
		.eq_cnt(eq_cnt), .pins({pair3_neg_pin, pair2_neg_pin, secondary_match_pin,
		primary_match_pin}));

	// Clock, and random levels on the external count inputs
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		seed    <= xs(seed);
		ext_clk <= seed[3:0];
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// High counts per period of a PWM pin, clear 1 on rise match
	function automatic int model_hi(input int clr, input int rise, input int fall);
		int per;
		int lvl;
		int hi;
		per = (clr == 1 ? rise : fall) + 1;
		lvl = 0;
		hi  = 0;
		for (int k = 0; k < 2 * per; k++) begin
			if (k % per == rise && rise != fall) lvl = 1;
			if (k % per == fall && rise != fall) lvl = 0;
			if (k >= per) hi += lvl;
		end
		return hi;
	endfunction : model_hi

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// One bus transfer; read data taken in rd at the edge that sees pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			print_verdict();
		end else begin
			rd = prdata;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	// Single register read into rd
	task automatic rd_reg(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd_reg

	// Open the load window for n cycles, then settle the counts
	task automatic measure(input int n);
		cnt_en <= 1'b1;
		repeat (n) @(posedge sys_clk);
		cnt_en <= 1'b0;
		@(negedge sys_clk);
	endtask : measure

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		int          clr [6]  = '{2, 2, 1, 2, 1, 2};
		int          rise [6] = '{1, 7, 3, 3, 6, 1};
		int          fall [6] = '{7, 3, 7, 3, 2, 5};
		int          psc [6]  = '{0, 0, 0, 0, 2, 3};
		int          turn [3] = '{3, 5, 7};
		int          pos [3]  = '{3, 4, 9};
		int          neg [3]  = '{8, 10, 11};
		int          ch;
		int          per;
		int          div;
		logic [11:0] base;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		check("pins", 32'h0, {20'h0, pair3_neg_pin, pair2_neg_pin, secondary_match_pin,
			primary_match_pin});
		rd_reg(tpwm_pkg::OFF_RISE);
		check("rise reset", {16'h0000, tpwm_pkg::GR_RESET}, rd);
		apb(1'b1, tpwm_pkg::OFF_FALL, 32'h0000_1234);
		rd_reg(tpwm_pkg::OFF_FALL);
		check("fall readback", 32'h0000_1234, rd);
		rd_reg(12'hffc);
		check("unmapped", 32'h0, rd);
		rise[0] = 1 + int'(seed % 32'd6);
		// PWM table: random duty, 0%, 100%, equal registers, prescaled counts
		for (int i = 0; i < 6; i++) begin
			ch   = i % 5;
			base = 12'(ch) * tpwm_pkg::CH_STRIDE;
			apb(1'b1, tpwm_pkg::ADDR_START, 32'h0);
			apb(1'b1, tpwm_pkg::ADDR_COMB, 32'h0);
			apb(1'b1, base + tpwm_pkg::OFF_COUNT, 32'h0);
			apb(1'b1, base + tpwm_pkg::OFF_CTRL, (32'(clr[i]) << tpwm_pkg::CTRL_CLR_LSB) | 32'(psc[i]));
			apb(1'b1, base + tpwm_pkg::OFF_IOCTL, (32'(tpwm_pkg::IO_ONE) << tpwm_pkg::IO_SEC_LSB)
				| 32'(tpwm_pkg::IO_TOGGLE));
			apb(1'b1, base + tpwm_pkg::OFF_RISE, 32'(rise[i]));
			apb(1'b1, base + tpwm_pkg::OFF_FALL, 32'(fall[i]));
			apb(1'b1, tpwm_pkg::ADDR_COMB, 32'h1 << ch);
			apb(1'b1, tpwm_pkg::ADDR_START, 32'h1 << ch);
			div = 1 << psc[i];
			per = (clr[i] == 1 ? rise[i] : fall[i]) + 1;
			repeat (3 * per * div) @(posedge sys_clk);
			measure(10 * per * div);
			check("pwm high", 32'(10 * div * model_hi(clr[i], rise[i], fall[i])),
				{16'h0, hi_cnt[ch]});
			if (clr[i] == 2) check("secondary", 32'h1, 32'(secondary_match_pin[ch]));
		end
		// Reset-synchronised mode, period 10 counts, channel 4 counter left running
		apb(1'b1, tpwm_pkg::ADDR_START, 32'h0);
		apb(1'b1, tpwm_pkg::ADDR_COMB, 32'h0);
		base = 12'h3 * tpwm_pkg::CH_STRIDE;
		apb(1'b1, base + tpwm_pkg::OFF_CTRL, 32'(tpwm_pkg::CLR_RISE) << tpwm_pkg::CTRL_CLR_LSB);
		apb(1'b1, base + tpwm_pkg::OFF_COUNT, 32'h0);
		apb(1'b1, base + tpwm_pkg::OFF_RISE, 32'd9);
		apb(1'b1, base + tpwm_pkg::OFF_FALL, 32'(turn[0]));
		apb(1'b1, base + tpwm_pkg::CH_STRIDE + tpwm_pkg::OFF_RISE, 32'(turn[1]));
		apb(1'b1, base + tpwm_pkg::CH_STRIDE + tpwm_pkg::OFF_FALL, 32'(turn[2]));
		apb(1'b1, tpwm_pkg::ADDR_COMB, 32'(tpwm_pkg::COMB_RSYNC) << 5);
		apb(1'b1, tpwm_pkg::ADDR_START, 32'h18);
		repeat (30) @(posedge sys_clk);
		measure(100);
		for (int p = 0; p < 3; p++) begin
			check("sync pos high", 32'(10 * (9 - turn[p])), {16'h0, hi_cnt[pos[p]]});
			check("sync neg high", 32'(10 * (1 + turn[p])), {16'h0, hi_cnt[neg[p]]});
		end
		check("pair equal cycles", 32'h0, {16'h0, eq_cnt});
		// Synchronised preset and clear: channel 1 PWM on channel 0's 6-count period
		apb(1'b1, tpwm_pkg::ADDR_START, 32'h3 << 5);
		apb(1'b1, tpwm_pkg::CH_STRIDE + tpwm_pkg::OFF_COUNT, 32'h2);
		rd_reg(tpwm_pkg::OFF_COUNT);
		check("sync preset", 32'h2, rd);
		apb(1'b1, tpwm_pkg::OFF_CTRL, 32'(tpwm_pkg::CLR_FALL) << tpwm_pkg::CTRL_CLR_LSB);
		apb(1'b1, tpwm_pkg::OFF_FALL, 32'h5);
		base = tpwm_pkg::CH_STRIDE;
		apb(1'b1, base + tpwm_pkg::OFF_CTRL, 32'(tpwm_pkg::CLR_SYNC) << tpwm_pkg::CTRL_CLR_LSB);
		apb(1'b1, base + tpwm_pkg::OFF_RISE, 32'h1);
		apb(1'b1, base + tpwm_pkg::OFF_FALL, 32'h3);
		apb(1'b1, tpwm_pkg::ADDR_COMB, 32'h2);
		apb(1'b1, tpwm_pkg::ADDR_START, (32'h3 << 5) | 32'h3);
		repeat (18) @(posedge sys_clk);
		measure(60);
		// High for counts 2 and 3 of every 6-count period, ten periods
		check("sync pwm high", 32'd20, {16'h0, hi_cnt[1]});
		print_verdict();
	end
endmodule : tpwm_top_test
`default_nettype wire
